// ==== mmd_datapath.v ====
/*
 Multiply datapath top: 16x16 multiply to half or full register,
 32x32 modulo multiply and multiply-accumulate into two 40-bit
 accumulators, with overflow and saturation flags.
 Assumes an Avalon-MM master that holds each request until it sees
 waitrequest low; each write of a legal command word executes one command.
*/
`timescale 1ns/1ps
`include "mmd_defines.vh"
module mmd_datapath (
  input  wire        clk,             // Core clock
  input  wire        nrst,            // Async reset, active low
  input  wire [5:0]  avs_address,     // Byte address
  input  wire        avs_read,        // Read request
  input  wire        avs_write,       // Write request
  input  wire [3:0]  avs_byteenable,  // Write byte lanes
  input  wire [31:0] avs_writedata,   // Write data
  output reg  [31:0] avs_readdata,    // Read data
  output reg         avs_waitrequest  // Stall, low marks completion
);

  ////////////////////////////////////////////////////////////////////
  // Bus state, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  reg [1:0]  state;
  reg [1:0]  next_state;

  // Programmer-visible state
  reg [9:0]  cmd;
  reg [31:0] src0;
  reg [31:0] src1;
  reg [31:0] result;
  reg [39:0] accum_0;
  reg [39:0] accum_1;
  reg        ovf_flag;
  reg        sticky_saturation_flag;
  reg        accum0_sat_flag;
  reg        accum0_sticky_sat_flag;
  reg        accum1_sat_flag;
  reg        accum1_sticky_sat_flag;
  reg        round_select_bit;
  reg        cmd_err;

  ////////////////////////////////////////////////////////////////////
  // Helpers
  // Clip a value to [lo, hi]; top bit flags saturation
  function [42:0] sat_clip;
    input [41:0] v;
    input [41:0] lo;
    input [41:0] hi;
    begin
      if ($signed(v) > $signed(hi)) begin
        sat_clip = {1'b1, hi};
      end else if ($signed(v) < $signed(lo)) begin
        sat_clip = {1'b1, lo};
      end else begin
        sat_clip = {1'b0, v};
      end
    end
  endfunction

  // Round at bit 16, unbiased ties clear the kept lsb
  function [41:0] rnd16;
    input [41:0] v;
    input        biased;
    reg   [41:0] t;
    begin
      t = v + `MMD_RND_HALF;
      if (!biased && v[15:0] == 16'h8000) begin
        t[16] = 1'b0;
      end
      rnd16 = t;
    end
  endfunction

  // Merge write data under byte enables
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer      i;
    begin
      lane_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          lane_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  wire [5:0] word_addr = {avs_address[5:2], 2'b00};
  wire       req       = avs_read | avs_write;
  wire       wr_fire   = (state == ST_DONE) & avs_write;
  wire       wr_cmd    = wr_fire & (word_addr == `MMD_REG_CMD);

  // Command fields, taken from the word being written
  wire [2:0] c_op   = avs_writedata[`MMD_CMD_OP_MSB:`MMD_CMD_OP_LSB];
  wire       c_unit = avs_writedata[`MMD_CMD_UNIT];
  wire       c_uf   = avs_writedata[`MMD_CMD_UFRAC];
  wire       c_is   = avs_writedata[`MMD_CMD_IS];
  wire       c_isx2 = avs_writedata[`MMD_CMD_SINT2X];
  wire       c_hx   = avs_writedata[`MMD_CMD_HIEXT];
  wire       c_m    = avs_writedata[`MMD_CMD_M];
  wire       c_s32  = avs_writedata[`MMD_CMD_SAT32];

  // The uf, is, isx2 and hx options are mutually exclusive, so their order cannot matter
  wire       is_mac  = (c_op == `MMD_OP_MACLD) | (c_op == `MMD_OP_MACADD) |
                       (c_op == `MMD_OP_MACSUB);
  wire       is_m16  = (c_op == `MMD_OP_MUL16H) | (c_op == `MMD_OP_MUL16W);
  wire       is_m32  = (c_op == `MMD_OP_MUL32);
  wire       intm    = c_is | c_isx2 | c_hx;
  wire       mixed   = c_m & c_unit;
  wire [2:0] n_excl  = {2'b00, c_uf} + {2'b00, c_is} + {2'b00, c_isx2} +
                       {2'b00, c_hx};

  // Illegal option combinations are refused, setting cmd_err; the 32-bit multiply ignores its options
  wire       bad_opt = (n_excl > 3'd1) |
                       (c_m & !c_unit) |
                       (!is_mac & c_s32) |
                       ((c_op == `MMD_OP_MUL16W) & c_hx) |
                       (is_mac & (c_isx2 | c_hx)) |
                       (is_mac & c_m & (c_uf | c_is)) |
                       (is_mac & c_s32 & (c_uf | c_is));
  wire       cmd_bad = !(is_mac | is_m16 | is_m32) | (!is_m32 & bad_opt);

  ////////////////////////////////////////////////////////////////////
  // Multiplier units, one per accumulator
  wire [32:0] prod0;
  wire [32:0] prod1;

  mmd_mul16 u_mult_unit_0 (
    .a        (src0[15:0]),
    .b        (src1[15:0]),
    .a_signed (!c_uf),
    .b_signed (!c_uf),
    .prod     (prod0)
  );

  // Mixed signedness: first signed, second unsigned
  mmd_mul16 u_mult_unit_1 (
    .a        (src0[15:0]),
    .b        (src1[15:0]),
    .a_signed (!c_uf),
    .b_signed (!c_uf & !c_m),
    .prod     (prod1)
  );

  ////////////////////////////////////////////////////////////////////
  // Product correction
  wire [32:0] prod    = c_unit ? prod1 : prod0;
  wire [41:0] px      = {{9{prod[32]}}, prod};
  wire [41:0] sx      = {{8{prod[32]}}, prod, 1'b0};
  // Left-shift only for signed fractions; mixed and integer stay put
  wire        f_shift = !intm & !c_uf & !mixed;
  wire        f_neg   = (src0[15:0] == `MMD_NEG_FRAC) & (src1[15:0] == `MMD_NEG_FRAC);
  wire        special = f_shift & f_neg;
  wire [41:0] fval    = special ? `MMD_FRAC_MAX :
                        (f_shift ? sx : px);

  ////////////////////////////////////////////////////////////////////
  // 16x16 to register results
  reg  [42:0] h_clip;
  reg  [15:0] h_val;
  reg  [42:0] w_clip;

  // Half destination
  always @* begin
    h_clip = sat_clip(px, `MMD_S16_MIN, `MMD_S16_MAX);
    h_val  = h_clip[15:0];
    if (c_isx2) begin
      h_clip = sat_clip(sx, `MMD_S16_MIN, `MMD_S16_MAX);
      h_val  = h_clip[15:0];
    end else if (c_hx) begin
      h_clip = sat_clip(rnd16(px, round_select_bit),
                        `MMD_S32_MIN, `MMD_S32_MAX);
      h_val  = h_clip[31:16];
    end else if (c_uf) begin
      h_clip = sat_clip(rnd16(fval, round_select_bit),
                        `MMD_U32_MIN, `MMD_U32_MAX);
      h_val  = h_clip[31:16];
    end else if (!c_is) begin
      h_clip = sat_clip(rnd16(fval, round_select_bit),
                        `MMD_S32_MIN, `MMD_S32_MAX);
      h_val  = h_clip[31:16];
      h_clip[42] = h_clip[42] | special;
    end
  end

  // Full-word destination
  always @* begin
    w_clip = sat_clip(px, `MMD_S32_MIN, `MMD_S32_MAX);
    if (c_isx2) begin
      w_clip = sat_clip(sx, `MMD_S32_MIN, `MMD_S32_MAX);
    end else if (c_uf) begin
      w_clip = sat_clip(fval, `MMD_U32_MIN, `MMD_U32_MAX);
    end else if (!c_is) begin
      w_clip = sat_clip(fval, `MMD_S32_MIN, `MMD_S32_MAX);
      w_clip[42] = w_clip[42] | special;
    end
  end

  wire        m16_sat = (c_op == `MMD_OP_MUL16H) ? h_clip[42] : w_clip[42];

  // Modulo product keeps the low word only
  wire [63:0] p32     = src0 * src1;
  wire [31:0] m32_val = p32[31:0];

  ////////////////////////////////////////////////////////////////////
  // Accumulator updates
  wire [39:0] acc0_nx;
  wire [39:0] acc1_nx;
  wire        acc0_sat;
  wire        acc1_sat;
  wire        a_add = (c_op == `MMD_OP_MACADD);
  wire        a_sub = (c_op == `MMD_OP_MACSUB);
  wire        a_uns = c_uf;
  // With mixed and 32-bit saturation both units clip at 32 bits
  wire        a_s32 = c_s32;

  mmd_acc40 u_acc_0 (
    .acc      (accum_0),
    .prod     (fval),
    .do_add   (a_add),
    .do_sub   (a_sub),
    .uns      (a_uns),
    .sat32    (a_s32),
    .acc_next (acc0_nx),
    .sat      (acc0_sat)
  );

  mmd_acc40 u_acc_1 (
    .acc      (accum_1),
    .prod     (fval),
    .do_add   (a_add),
    .do_sub   (a_sub),
    .uns      (a_uns),
    .sat32    (a_s32),
    .acc_next (acc1_nx),
    .sat      (acc1_sat)
  );

  wire go     = wr_cmd & !cmd_bad;
  wire go_m16 = go & is_m16;
  wire go_m32 = go & is_m32;
  wire go_acc0 = go & is_mac & !c_unit;
  wire go_acc1 = go & is_mac & c_unit;

  ////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait state per access
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Read mux; unmapped reads return zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = `MMD_RST_WORD;
    case (word_addr)
      `MMD_REG_CMD:     rd_mux = {16'h0000, cmd[2:0] != `MMD_OP_MUL32,
                                  5'h00, cmd};
      `MMD_REG_SRC0:    rd_mux = src0;
      `MMD_REG_SRC1:    rd_mux = src1;
      `MMD_REG_RESULT:  rd_mux = result;
      `MMD_REG_STATUS:  rd_mux = {24'h000000, cmd_err, round_select_bit,
                                  accum1_sticky_sat_flag, accum1_sat_flag,
                                  accum0_sticky_sat_flag, accum0_sat_flag,
                                  sticky_saturation_flag, ovf_flag};
      `MMD_REG_ACC0_LO: rd_mux = accum_0[31:0];
      `MMD_REG_ACC0_HI: rd_mux = {24'h000000, accum_0[39:32]};
      `MMD_REG_ACC1_LO: rd_mux = accum_1[31:0];
      `MMD_REG_ACC1_HI: rd_mux = {24'h000000, accum_1[39:32]};
      default:          rd_mux = `MMD_RST_WORD;
    endcase
  end

  // Bus outputs and state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state           <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `MMD_RST_WORD;
    end else begin
      state           <= next_state;
      avs_waitrequest <= !((state == ST_IDLE) & req);
      if ((state == ST_IDLE) & req) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Operand, result and accumulator registers
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd     <= `MMD_RST_CMD;
      src0    <= `MMD_RST_WORD;
      src1    <= `MMD_RST_WORD;
      result  <= `MMD_RST_WORD;
      accum_0 <= `MMD_RST_ACC;
      accum_1 <= `MMD_RST_ACC;
    end else begin
      if (wr_cmd) begin
        cmd <= avs_writedata[9:0];
      end
      if (wr_fire & (word_addr == `MMD_REG_SRC0)) begin
        src0 <= lane_merge(src0, avs_writedata, avs_byteenable);
      end else if (go_m32) begin
        src0 <= m32_val;
      end
      // Multiplier register is written only by software
      if (wr_fire & (word_addr == `MMD_REG_SRC1)) begin
        src1 <= lane_merge(src1, avs_writedata, avs_byteenable);
      end
      if (go_m32) begin
        result <= m32_val;
      end else if (go_m16 & (c_op == `MMD_OP_MUL16W)) begin
        result <= w_clip[31:0];
      end else if (go_m16 & c_unit) begin
        result[31:16] <= h_val;
      end else if (go_m16) begin
        result[15:0] <= h_val;
      end
      // Each unit owns one accumulator
      if (go_acc0) begin
        accum_0 <= acc0_nx;
      end
      if (go_acc1) begin
        accum_1 <= acc1_nx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status flags; a set in the same cycle beats a clear
  wire st_wr = wr_fire & (word_addr == `MMD_REG_STATUS) & avs_byteenable[0];
  wire [7:0] st_clr = st_wr ? avs_writedata[7:0] : 8'h00;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ovf_flag               <= `MMD_RST_BIT;
      sticky_saturation_flag <= `MMD_RST_BIT;
      accum0_sat_flag        <= `MMD_RST_BIT;
      accum0_sticky_sat_flag <= `MMD_RST_BIT;
      accum1_sat_flag        <= `MMD_RST_BIT;
      accum1_sticky_sat_flag <= `MMD_RST_BIT;
      round_select_bit       <= `MMD_RST_BIT;
      cmd_err                <= `MMD_RST_BIT;
    end else begin
      if (st_wr) begin
        round_select_bit <= avs_writedata[`MMD_ST_RND];
      end
      // The 32x32 modulo multiply never reaches these flags
      if (go_m16) begin
        ovf_flag <= m16_sat;
      end
      sticky_saturation_flag <= (go_m16 & m16_sat) |
                                (sticky_saturation_flag & !st_clr[`MMD_ST_OVFS]);
      if (go_acc0) begin
        accum0_sat_flag <= acc0_sat;
      end
      accum0_sticky_sat_flag <= (go_acc0 & acc0_sat) |
                                (accum0_sticky_sat_flag & !st_clr[`MMD_ST_ACC0STK]);
      if (go_acc1) begin
        accum1_sat_flag <= acc1_sat;
      end
      accum1_sticky_sat_flag <= (go_acc1 & acc1_sat) |
                                (accum1_sticky_sat_flag & !st_clr[`MMD_ST_ACC1STK]);
      cmd_err <= (wr_cmd & cmd_bad) | (cmd_err & !st_clr[`MMD_ST_ERR]);
    end
  end

endmodule // mmd_datapath

// ==== mmd_defines.vh ====
/*
 Register map, field positions, operation codes, reset values and
 saturation limits for the multiply datapath.
 Assumes inclusion by bare name from the datapath top and accumulator files.
*/
`ifndef MMD_DEFINES_VH
`define MMD_DEFINES_VH

////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define MMD_REG_CMD      6'h00
`define MMD_REG_SRC0     6'h04
`define MMD_REG_SRC1     6'h08
`define MMD_REG_RESULT   6'h0C
`define MMD_REG_STATUS   6'h10
`define MMD_REG_ACC0_LO  6'h14
`define MMD_REG_ACC0_HI  6'h18
`define MMD_REG_ACC1_LO  6'h1C
`define MMD_REG_ACC1_HI  6'h20

////////////////////////////////////////////////////////////////////////
// Command register fields
`define MMD_CMD_OP_LSB   0
`define MMD_CMD_OP_MSB   2
`define MMD_CMD_UNIT     3
`define MMD_CMD_UFRAC    4
`define MMD_CMD_IS       5
`define MMD_CMD_SINT2X   6
`define MMD_CMD_HIEXT    7
`define MMD_CMD_M        8
`define MMD_CMD_SAT32    9
`define MMD_CMD_LEN32    15

// Operation codes
`define MMD_OP_MUL16H    3'h0
`define MMD_OP_MUL16W    3'h1
`define MMD_OP_MUL32     3'h2
`define MMD_OP_MACLD     3'h3
`define MMD_OP_MACADD    3'h4
`define MMD_OP_MACSUB    3'h5

////////////////////////////////////////////////////////////////////////
// Status register fields
`define MMD_ST_OVF       0
`define MMD_ST_OVFS      1
`define MMD_ST_ACC0SAT   2
`define MMD_ST_ACC0STK   3
`define MMD_ST_ACC1SAT   4
`define MMD_ST_ACC1STK   5
`define MMD_ST_RND       6
`define MMD_ST_ERR       7

// Round select value meaning biased rounding
`define MMD_RND_BIASED   1'b1

////////////////////////////////////////////////////////////////////////
// Reset values
`define MMD_RST_WORD     32'h00000000
`define MMD_RST_ACC      40'h0000000000
`define MMD_RST_CMD      10'h000
`define MMD_RST_BIT      1'b0

////////////////////////////////////////////////////////////////////////
// Saturation limits, rounding constant and fraction maximum, 42-bit two's complement; 16-bit fraction minus one
`define MMD_S16_MIN      42'h3FFFFFF8000
`define MMD_S16_MAX      42'h00000007FFF
`define MMD_S32_MIN      42'h3FF80000000
`define MMD_S32_MAX      42'h0007FFFFFFF
`define MMD_U32_MIN      42'h00000000000
`define MMD_U32_MAX      42'h000FFFFFFFF
`define MMD_S40_MIN      42'h3F800000000
`define MMD_S40_MAX      42'h007FFFFFFFF
`define MMD_U40_MAX      42'h0FFFFFFFFFF
`define MMD_RND_HALF     42'h00000008000
`define MMD_FRAC_MAX     42'h0007FFFFFFF
`define MMD_NEG_FRAC     16'h8000

`endif

// ==== mmd_mul16.v ====
/*
 One 16x16 multiplier unit with per-operand signedness.
 Assumes purely combinational use inside the datapath top.
*/
`timescale 1ns/1ps
module mmd_mul16 (
  input  wire [15:0] a,        // First source operand
  input  wire [15:0] b,        // Second source operand
  input  wire        a_signed, // First operand is signed
  input  wire        b_signed, // Second operand is signed
  output wire [32:0] prod      // Product, two's complement
);
  // Extend each operand by its own signedness
  wire signed [16:0] ax = {a_signed & a[15], a};
  wire signed [16:0] bx = {b_signed & b[15], b};
  wire signed [33:0] px = ax * bx;

  assign prod = px[32:0];
endmodule // mmd_mul16

// ==== mmd_acc40.v ====
/*
 Accumulator update for one multiplier unit: load, add or subtract
 the corrected product, then saturate to 32 bits, 36 bits signed or 40 bits unsigned.
 Assumes the top writes the result only for the selected unit.
*/
`timescale 1ns/1ps
`include "mmd_defines.vh"
module mmd_acc40 (
  input  wire [39:0] acc,      // Present accumulator
  input  wire [41:0] prod,     // Extended, corrected product
  input  wire        do_add,   // Add product
  input  wire        do_sub,   // Subtract product
  input  wire        uns,      // Unsigned accumulation
  input  wire        sat32,    // Saturate at bit 31
  output reg  [39:0] acc_next, // Saturated new value
  output reg         sat       // Result saturated
);
  wire [41:0] accx = uns ? {2'b00, acc} : {{2{acc[39]}}, acc};
  reg  [41:0] sum;
  reg  [41:0] lo;
  reg  [41:0] hi;

  // Combine and clip to the selected range
  always @* begin
    sum = prod;
    if (do_add) begin
      sum = accx + prod;
    end else if (do_sub) begin
      sum = accx - prod;
    end
    if (sat32) begin
      lo = `MMD_S32_MIN;
      hi = `MMD_S32_MAX;
    end else if (uns) begin
      lo = `MMD_U32_MIN;
      hi = `MMD_U40_MAX;
    end else begin
      lo = `MMD_S40_MIN;
      hi = `MMD_S40_MAX;
    end
    sat = 1'b0;
    acc_next = sum[39:0];
    if ($signed(sum) > $signed(hi)) begin
      sat = 1'b1;
      acc_next = hi[39:0];
    end else if ($signed(sum) < $signed(lo)) begin
      sat = 1'b1;
      acc_next = lo[39:0];
    end
  end
endmodule // mmd_acc40

// ==== mmd_dp_sva.sv ====
/* Port checks for the multiply datapath: bus handshake and status.
 Assumes bind from the bench top, one clock, async low reset. */
`timescale 1ns/1ps
`include "mmd_defines.vh"
module mmd_dp_sva (
  input wire        clk,             // Core clock
  input wire        nrst,            // Reset, active low
  input wire [5:0]  avs_address,     // Byte address
  input wire        avs_read,        // Read request
  input wire        avs_write,       // Write request
  input wire [3:0]  avs_byteenable,  // Byte lanes
  input wire [31:0] avs_writedata,   // Write data
  input wire [31:0] avs_readdata,    // Read data
  input wire        avs_waitrequest  // Stall
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////
  // Shadows of last command and multiplier words
  reg  [31:0] src1_sh;
  reg  [9:0]  cmd_sh;
  wire        wr_done = avs_write && !avs_waitrequest;
  wire        rd_done = avs_read && !avs_waitrequest;
  wire [5:0]  adr     = {avs_address[5:2], 2'b00};
  integer     i;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src1_sh <= 32'h00000000;
      cmd_sh  <= 10'h000;
    end else if (wr_done) begin
      if (adr == `MMD_REG_CMD) cmd_sh <= avs_writedata[9:0];
      for (i = 0; i < 4; i = i + 1)
        if (adr == `MMD_REG_SRC1 && avs_byteenable[i]) src1_sh[i*8 +: 8] <= avs_writedata[i*8 +: 8];
    end
  end
  ////////////////////////////////////////////////////////////////////
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  property p_answer; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("no answer after one wait state");
  property p_idle_hold; !avs_read && !avs_write |=> $stable(avs_readdata); endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("readdata moved while idle");
  property p_cmd_len;
    rd_done && adr == `MMD_REG_CMD |-> avs_readdata[9:0] == cmd_sh
      && avs_readdata[`MMD_CMD_LEN32] == (cmd_sh[2:0] != `MMD_OP_MUL32);
  endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("command length bit wrong");
  property p_src1_kept; rd_done && adr == `MMD_REG_SRC1 |-> avs_readdata == src1_sh; endproperty
  a_src1_kept: assert property (p_src1_kept) else $error("multiplier word altered");
  property p_ovf_sticky;
    rd_done && adr == `MMD_REG_STATUS && avs_readdata[`MMD_ST_OVF] |-> avs_readdata[`MMD_ST_OVFS];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow without sticky");
  property p_acc0_sticky;
    rd_done && adr == `MMD_REG_STATUS && avs_readdata[`MMD_ST_ACC0SAT] |-> avs_readdata[`MMD_ST_ACC0STK];
  endproperty
  a_acc0_sticky: assert property (p_acc0_sticky) else $error("acc0 sat without sticky");
  property p_acc1_sticky;
    rd_done && adr == `MMD_REG_STATUS && avs_readdata[`MMD_ST_ACC1SAT] |-> avs_readdata[`MMD_ST_ACC1STK];
  endproperty
  a_acc1_sticky: assert property (p_acc1_sticky) else $error("acc1 sat without sticky");
  // Main scenarios reached
  c_ovf: cover property (rd_done && adr == `MMD_REG_STATUS && avs_readdata[`MMD_ST_OVF]);
  c_sat0: cover property (rd_done && adr == `MMD_REG_STATUS && avs_readdata[`MMD_ST_ACC0SAT]);
  c_mul32: cover property (wr_done && adr == `MMD_REG_CMD && avs_writedata[2:0] == `MMD_OP_MUL32);
endmodule // mmd_dp_sva

// ==== mmd_host_model.sv ====
/* Issue-side model: one Avalon-MM transfer per call of xfer.
 Assumes one caller at a time; bench watchdog ends any hang. */
`timescale 1ns/1ps
module mmd_host_model (
  input  wire         clk,             // Core clock
  input  wire         avs_waitrequest, // Stall from block
  output logic [5:0]  avs_address,     // Byte address
  output logic        avs_read,        // Read request
  output logic        avs_write,       // Write request
  output logic [3:0]  avs_byteenable,  // Byte lanes
  output logic [31:0] avs_writedata    // Write data
);
  // Idle bus at time zero
  initial begin
    avs_address    = 6'h3F;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata  = 32'h00000000;
  end
  // Hold request until waitrequest is sampled low, then scramble lines
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_address   <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule // mmd_host_model

// ==== tb_mac_multiply_datapath.sv ====
/* Self-checking bench for the multiply datapath.
 Assumes the host model drives the bus; reads are judged from a queue. */
`timescale 1ns/1ps
`include "mmd_defines.vh"
module tb_mac_multiply_datapath;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  wire  [5:0]  adr;
  wire         rd_s;
  wire         wr_s;
  wire  [3:0]  be;
  wire  [31:0] wd;
  wire  [31:0] rdat;
  wire         wreq;
  int          n_fail = 0;
  int          num_checks = 0;
  logic [31:0] exp_q[$];
  logic [31:0] ra;
  logic [31:0] rb;
  always #2 clk = ~clk;
  mmd_datapath u_dut (.clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq));
  mmd_host_model u_host (.clk(clk), .avs_waitrequest(wreq), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_byteenable(be), .avs_writedata(wd));
  ////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  // Oldest note against each completed read
  always @(posedge clk) if (rd_s === 1'b1 && wreq === 1'b0) check(rdat, exp_q.pop_front());
  task rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 32'h00000000);
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  // Operands, command, then one result and the status
  task run(input logic [31:0] c, s0, s1, input logic [5:0] a, input logic [31:0] v, st);
    wr(`MMD_REG_SRC0, s0);
    wr(`MMD_REG_SRC1, s1);
    wr(`MMD_REG_CMD, c);
    rd(a, v);
    rd(`MMD_REG_STATUS, st);
  endtask
  task final_report;
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #80000;
    n_fail++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(91619));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(`MMD_REG_STATUS, 32'h0);
    rd(`MMD_REG_RESULT, 32'h0);
    run(32'h041, 32'h4000, 32'h4000, `MMD_REG_RESULT, 32'h20000000, 32'h0);
    run(32'h041, 32'h8000, 32'h8000, `MMD_REG_RESULT, 32'h7FFFFFFF, 32'h3);
    run(32'h041, 32'h8000, 32'h7FFF, `MMD_REG_RESULT, 32'h80010000, 32'h2);
    wr(`MMD_REG_STATUS, 32'h02);
    run(32'h040, 32'h0010, 32'h0010, `MMD_REG_RESULT, 32'h80010200, 32'h0);
    run(32'h040, 32'h0100, 32'h0100, `MMD_REG_RESULT, 32'h80017FFF, 32'h3);
    run(32'h040, 32'h8000, 32'h0100, `MMD_REG_RESULT, 32'h80018000, 32'h3);
    wr(`MMD_REG_STATUS, 32'h02);
    run(32'h088, 32'h0080, 32'h0100, `MMD_REG_RESULT, 32'h00008000, 32'h0);
    wr(`MMD_REG_STATUS, 32'h40);
    run(32'h088, 32'h0080, 32'h0100, `MMD_REG_RESULT, 32'h00018000, 32'h40);
    run(32'h010, 32'hFFFF, 32'hFFFF, `MMD_REG_RESULT, 32'h0001FFFE, 32'h40);
    $display("test half and word done");
    run(32'h129, 32'hFFFF, 32'hFFFF, `MMD_REG_RESULT, 32'hFFFF0001, 32'h40);
    run(32'h109, 32'h4000, 32'h8000, `MMD_REG_RESULT, 32'h20000000, 32'h40);
    run(32'h101, 32'h4000, 32'h8000, `MMD_REG_RESULT, 32'h20000000, 32'hC0);
    wr(`MMD_REG_STATUS, 32'h80);
    $display("test mixed done");
    run(32'h003, 32'h4000, 32'h4000, `MMD_REG_ACC0_LO, 32'h20000000, 32'h0);
    run(32'h004, 32'h4000, 32'h4000, `MMD_REG_ACC0_LO, 32'h40000000, 32'h0);
    run(32'h005, 32'h4000, 32'hC000, `MMD_REG_ACC0_LO, 32'h60000000, 32'h0);
    rd(`MMD_REG_ACC1_LO, 32'h0);
    run(32'h003, 32'h8000, 32'h8000, `MMD_REG_ACC0_LO, 32'h7FFFFFFF, 32'h0);
    run(32'h204, 32'h4000, 32'h4000, `MMD_REG_ACC0_LO, 32'h7FFFFFFF, 32'h0C);
    rd(`MMD_REG_ACC0_HI, 32'h0);
    run(32'h30B, 32'h4000, 32'h8000, `MMD_REG_ACC1_LO, 32'h20000000, 32'h0C);
    run(32'h02B, 32'hFFFF, 32'h0002, `MMD_REG_ACC1_HI, 32'h000000FF, 32'h0C);
    rd(`MMD_REG_ACC1_LO, 32'hFFFFFFFE);
    run(32'h083, 32'h4000, 32'h4000, `MMD_REG_ACC0_LO, 32'h7FFFFFFF, 32'h8C);
    wr(`MMD_REG_STATUS, 32'h80);
    run(32'h01B, 32'h0001, 32'h0001, `MMD_REG_ACC1_LO, 32'h00000001, 32'h0C);
    run(32'h01D, 32'h0001, 32'h0002, `MMD_REG_ACC1_LO, 32'h00000000, 32'h3C);
    run(32'h01B, 32'h0001, 32'h0001, `MMD_REG_ACC1_LO, 32'h00000001, 32'h2C);
    wr(`MMD_REG_STATUS, 32'h20);
    $display("test accumulate done");
    for (int k = 0; k < 3; k++) begin
      ra = $urandom;
      rb = $urandom;
      wr(`MMD_REG_SRC0, ra);
      wr(`MMD_REG_SRC1, rb);
      wr(`MMD_REG_CMD, 32'h002);
      rd(`MMD_REG_SRC0, ra * rb);
      rd(`MMD_REG_SRC1, rb);
      rd(`MMD_REG_STATUS, 32'h0C);
      rd(`MMD_REG_ACC0_LO, 32'h7FFFFFFF);
    end
    rd(`MMD_REG_CMD, 32'h00000002);
    rd(6'h3C, 32'h0);
    $display("test modulo multiply done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(`MMD_REG_STATUS, 32'h0);
    rd(`MMD_REG_ACC1_LO, 32'h0);
    $display("test second reset done");
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule // tb_mac_multiply_datapath
bind mmd_datapath mmd_dp_sva u_sva (.clk(clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
